// ===== dv/sbp_port_sva.sv
// Checker on the pins that join the memory device and its controller.
`timescale 1ns/10ps
`include "sbp_defs.svh"
module sbp_port_sva (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Command pins.
    input wire logic adv_ld,
    input wire logic we_n,
    input wire logic device_select_1_n,
    input wire logic clock_qualify_n,
    input wire logic oe_n,
    input wire logic sleep_request,
    // Data bus drivers.
    input wire logic [`SBP_DW-1:0] dev_dq,
    input wire logic dev_dq_oe,
    input wire logic ctl_dq_oe
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    // A selected load taken on an enabled edge; sleep makes the device ignore it.
    sequence rd_load;
        !clock_qualify_n && !adv_ld && we_n && !device_select_1_n && !sleep_request;
    endsequence
    sequence wr_load;
        !clock_qualify_n && !adv_ld && !we_n && !device_select_1_n && !sleep_request;
    endsequence
    // Two further enabled edges bring the data phase.
    sequence run2;
        !clock_qualify_n [*2];
    endsequence

    a_no_bus_fight: assert property (!(dev_dq_oe && ctl_dq_oe))
        else $error("both ends drive the data bus");
    a_oe_gates_drive: assert property (oe_n |-> !dev_dq_oe)
        else $error("device drives while output enable is off");
    a_read_two_edges: assert property (rd_load ##1 run2 |=> dev_dq_oe || oe_n)
        else $error("read data not driven two enabled edges after load");
    a_write_two_edges: assert property (wr_load ##1 run2 |=> ctl_dq_oe && !dev_dq_oe)
        else $error("write data phase not owned by the controller");
    a_wr_then_rd: assert property (wr_load ##1 rd_load ##1 run2 |=> dev_dq_oe || oe_n)
        else $error("read right behind a write lost its slot");
    a_idle_quiet: assert property (!clock_qualify_n && !adv_ld && device_select_1_n ##1 run2
        |=> !dev_dq_oe)
        else $error("device drove after an unselected load");
    a_out_registered: assert property ($changed(dev_dq) |-> !$past(clock_qualify_n))
        else $error("read data moved without an enabled edge");
    a_drive_stands: assert property (dev_dq_oe && clock_qualify_n
        |=> $stable(dev_dq) && (dev_dq_oe || oe_n))
        else $error("read data changed on a suspended edge");
endmodule : sbp_port_sva

// ===== dv/tb_pipelined_sync_burst_sram_port.sv
// Self-checking bench: controller and memory device joined over the pin carrier.
`timescale 1ns/10ps
`include "sbp_defs.svh"
module tb_pipelined_sync_burst_sram_port;
    logic ref_clk, arst_n = 0, ilv = 0, hold = 0, sleep = 0, rsp_ready = 0, asleep;
    logic req_valid = 0, req_write = 0, req_burst = 0, req_ready, rsp_valid, rb;
    logic [`SBP_AW-1:0] req_addr = '0, base = '0;
    logic [`SBP_DW-1:0] req_wdata = '0, rsp_data;
    logic [`SBP_LANES-1:0] req_lanes = '0;
    logic [`SBP_DW-1:0] mem [`SBP_STORE_DEPTH] = '{default: '0};
    logic [`SBP_DW-1:0] expq [$];
    logic [1:0] prev_op = 2'h0, bcnt = 2'h0;
    int fail_count = 0, cmp_count = 0, cyc = 0, ecyc = 0, last_take = -5, mode = 1, k;
    bit ok;

    sbp_if bus_if ();
    sbp_dev sbp_dev_inst (.ref_clk_in(ref_clk), .arst_n_in(arst_n), .bus(bus_if),
        .burst_interleave_in(ilv), .asleep_out(asleep));
    sbp_ctl sbp_ctl_inst (.ref_clk_in(ref_clk), .arst_n_in(arst_n), .bus(bus_if),
        .req_valid_in(req_valid), .req_ready_out(req_ready), .req_write_in(req_write),
        .req_burst_in(req_burst), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
        .req_lanes_in(req_lanes), .hold_in(hold), .sleep_in(sleep),
        .rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready), .rsp_data_out(rsp_data));
    sbp_port_sva sbp_port_sva_inst (.ref_clk_in(ref_clk), .arst_n_in(arst_n),
        .adv_ld(bus_if.adv_ld), .we_n(bus_if.we_n),
        .device_select_1_n(bus_if.device_select_1_n),
        .clock_qualify_n(bus_if.clock_qualify_n), .oe_n(bus_if.oe_n),
        .sleep_request(bus_if.sleep_request), .dev_dq(bus_if.dev_dq),
        .dev_dq_oe(bus_if.dev_dq_oe), .ctl_dq_oe(bus_if.ctl_dq_oe));

    // Free-running 200 MHz clock.
    initial begin
        ref_clk = 0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Only the lanes selected by the write take the new bytes.
    function automatic logic [`SBP_DW-1:0] merge(input logic [`SBP_DW-1:0] o,
            input logic [`SBP_DW-1:0] w, input logic [`SBP_LANES-1:0] l);
        for (int i = 0; i < `SBP_LANES; i++) begin
            if (l[i]) o[i*`SBP_LANE_W +: `SBP_LANE_W] = w[i*`SBP_LANE_W +: `SBP_LANE_W];
        end
        return o;
    endfunction : merge

    // Burst address wraps inside four words, counting up or flipping bits.
    function automatic logic [3:0] baddr(input logic [3:0] b, input logic [1:0] c,
            input logic m);
        return {b[3:2], m ? (b[1:0] ^ c) : (b[1:0] + c)};
    endfunction : baddr

    task automatic check(input logic [`SBP_DW-1:0] seen, input logic [`SBP_DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    // One request held until taken or for at most 24 edges; the model follows only what was taken.
    task automatic send(input logic w, input logic b, input logic [3:0] a,
            input logic [3:0] l, output bit took);
        logic [3:0] ea;
        took = 0;
        @(negedge ref_clk);
        req_valid = 1;
        req_write = w;
        req_burst = b;
        req_addr = {14'($urandom), a};
        req_lanes = l;
        req_wdata = 36'({$urandom, $urandom});
        for (int i = 0; i < 24 && !took; i++) begin
            @(posedge ref_clk);
            took = req_ready;
        end
        if (took) begin
            if (b) begin
                bcnt++;
                // Suspended edges do not break a burst; an enabled edge without a take does.
                if (ecyc != last_take + 1) prev_op = 2'h0;
                ea = baddr(base[3:0], bcnt, ilv);
            end else begin
                prev_op = w ? 2'h2 : 2'h1;
                base = req_addr;
                bcnt = 2'h0;
                ea = a;
            end
            last_take = ecyc;
            if (prev_op == 2'h2) mem[ea] = merge(mem[ea], req_wdata, l);
            if (prev_op == 2'h1) expq.push_back(mem[ea]);
        end
    endtask : send

    task automatic idle(input int c);
        @(negedge ref_clk);
        req_valid = 0;
        repeat (c) @(negedge ref_clk);
    endtask : idle

    // Cycle count, hang guard and read-data comparison on each handover.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        ecyc <= ecyc + int'(!bus_if.clock_qualify_n);
        if (cyc > 20000) begin
            fail_count++;
            end_of_test();
        end
        if (arst_n && rsp_valid && rsp_ready) begin
            check(36'(expq.size() > 0), 36'h1);
            if (expq.size() > 0) check(rsp_data, expq.pop_front());
        end
    end

    // Read-side stalls and request holds: random, full stall, or free flow.
    always @(negedge ref_clk) begin
        rsp_ready = (mode == 2) || (mode == 0 && ($urandom % 4) != 0);
        hold = (mode == 0) && (($urandom % 8) == 0);
    end

    initial begin
        void'($urandom(20074));
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1;
        check(rsp_valid, 36'h0);
        mode = 0;
        // Random mix of reads, writes and bursts in both burst orders.
        for (int m = 0; m < 2; m++) begin
            @(negedge ref_clk);
            ilv = m[0];
            for (int n = 0; n < 150; n++) begin
                rb = ($urandom % 3) == 0;
                send(1'($urandom), rb, 4'($urandom), rb ? 4'hf : 4'($urandom), ok);
                check(ok, 36'h1);
            end
            idle(30);
        end
        // Partial write, then a read of the same word on the very next edge.
        send(1'b1, 1'b0, 4'h9, 4'h5, ok);
        send(1'b0, 1'b0, 4'h9, 4'h0, ok);
        // Drain the buffer first, then stall the read side until reads are refused.
        mode = 2;
        idle(20);
        mode = 1;
        idle(20);
        k = 0;
        do begin
            send(1'b0, 1'b0, 4'($urandom), 4'h0, ok);
            k += ok;
        end while (ok && k < 20);
        check(36'(k), 36'h10);
        mode = 2;
        idle(40);
        // Sleep refuses requests and idles the device; waking resumes traffic.
        sleep = 1;
        idle(4);
        check(asleep, 36'h1);
        send(1'b0, 1'b0, 4'h9, 4'h0, ok);
        check(ok, 36'h0);
        idle(1);
        sleep = 0;
        idle(4);
        check(asleep, 36'h0);
        send(1'b0, 1'b0, 4'h9, 4'h0, ok);
        idle(40);
        check(36'(expq.size()), 36'h0);
        end_of_test();
    end
endmodule : tb_pipelined_sync_burst_sram_port

// ===== src/sbp_ctl.sv
// Controller end: issues commands, drives write data, buffers read data.
`timescale 1ns/10ps
`include "sbp_defs.svh"
module sbp_fifo #(
    parameter int W = `SBP_DW,
    parameter int D = `SBP_FIFO_DEPTH,
    parameter int AW = `SBP_FIFO_AW
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Filling side.
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    // Draining side.
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out,
    // Fill level.
    output logic [AW:0] level_out
);

    // Whole buffer state in one register.
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sbp_fifo_st_t;

    sbp_fifo_st_t st_q;
    sbp_fifo_st_t st_d;
    logic push;
    logic pop;

    // Handshakes on both sides; full and empty come from the count.
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    // The count is one bit wider than the pointers, so a full buffer is
    // told apart from an empty one.
    assign in_ready_out = (st_q.cnt != (AW+1)'(D));
    assign out_valid_out = (st_q.cnt != '0);
    assign out_data_out = st_q.mem[st_q.rp];
    assign level_out = st_q.cnt;

    // Pointer and count update.
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = in_data_in;
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : sbp_fifo

module sbp_ctl (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Pins facing the memory.
    sbp_if.ctl bus,
    // Request side.
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic req_write_in,
    input wire logic req_burst_in,
    input wire logic [`SBP_AW-1:0] req_addr_in,
    input wire logic [`SBP_DW-1:0] req_wdata_in,
    input wire logic [`SBP_LANES-1:0] req_lanes_in,
    // Suspend and sleep controls.
    input wire logic hold_in,
    input wire logic sleep_in,
    // Read data side.
    output logic rsp_valid_out,
    input wire logic rsp_ready_in,
    output logic [`SBP_DW-1:0] rsp_data_out
);

    // Whole controller state: pin registers plus the data pipeline.
    typedef struct packed {
        logic [`SBP_AW-1:0] addr;
        logic adv_ld;
        logic we_n;
        logic [`SBP_LANES-1:0] bw_n;
        logic cs1_n;
        logic cq_n;
        logic sleep;
        sbp_pkg::sbp_op_t last;
        sbp_pkg::sbp_slot_t c;
        sbp_pkg::sbp_slot_t q1;
        sbp_pkg::sbp_slot_t q2;
        sbp_pkg::sbp_slot_t q3;
        logic [`SBP_DW-1:0] dq;
        logic dq_oe;
    } sbp_ctl_st_t;

    sbp_ctl_st_t st_q;
    sbp_ctl_st_t st_d;
    logic enabled;
    logic [`SBP_FIFO_AW:0] level;
    logic fifo_ready;
    logic [2:0] reads;

    // Reads not yet buffered; a request is taken only if their data will fit.
    always_comb begin
        reads = '0;
        reads = reads + 3'(st_q.c.op == sbp_pkg::SBP_RD);
        reads = reads + 3'(st_q.q1.op == sbp_pkg::SBP_RD);
        reads = reads + 3'(st_q.q2.op == sbp_pkg::SBP_RD);
        reads = reads + 3'(st_q.q3.op == sbp_pkg::SBP_RD);
    end

    // The memory sees the qualify pin as registered here, so the pipeline
    // here advances on exactly the same edges as the memory's.
    assign enabled = ~st_q.cq_n;
    assign req_ready_out = enabled & ~sleep_in & ~st_q.sleep
        & ((`SBP_FIFO_AW+1)'(reads) + level < (`SBP_FIFO_AW+1)'(`SBP_FIFO_DEPTH));

    // Next-state logic.
    always_comb begin
        st_d = st_q;
        st_d.cq_n = hold_in;
        st_d.sleep = sleep_in;
        if (enabled) begin
            st_d.q1 = st_q.c;
            st_d.q2 = st_q.q1;
            st_d.q3 = st_q.q2;
            // Write data goes out two edges after the memory sampled it.
            st_d.dq = st_q.q2.wdata;
            st_d.dq_oe = (st_q.q2.op == sbp_pkg::SBP_WR);
            // Default next pin set: a deselect that also breaks any burst.
            st_d.adv_ld = 1'b0;
            st_d.cs1_n = 1'b1;
            st_d.we_n = 1'b1;
            st_d.bw_n = '1;
            st_d.c.op = sbp_pkg::SBP_NOP;
            st_d.last = sbp_pkg::SBP_NOP;
            if (req_valid_in && req_ready_out) begin
                st_d.c.wdata = req_wdata_in;
                if (req_burst_in) begin
                    // Continue: the memory picks the address and the kind.
                    st_d.adv_ld = 1'b1;
                    st_d.c.op = st_q.last;
                    st_d.last = st_q.last;
                end else begin
                    st_d.cs1_n = 1'b0;
                    st_d.addr = req_addr_in;
                    st_d.we_n = ~req_write_in;
                    st_d.c.op = req_write_in ? sbp_pkg::SBP_WR : sbp_pkg::SBP_RD;
                    st_d.last = st_d.c.op;
                end
                if (st_d.c.op == sbp_pkg::SBP_WR) begin
                    st_d.bw_n = ~req_lanes_in;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= '0;
            st_q.cs1_n <= 1'b1;
            st_q.we_n <= 1'b1;
            st_q.bw_n <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    // Read data is caught on the edge after the memory launched it.
    sbp_fifo #(
        .W(`SBP_DW),
        .D(`SBP_FIFO_DEPTH),
        .AW(`SBP_FIFO_AW)
    ) u_rd_fifo (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .in_valid_in(enabled && st_q.q3.op == sbp_pkg::SBP_RD),
        .in_ready_out(fifo_ready),
        .in_data_in(bus.dq),
        .out_valid_out(rsp_valid_out),
        .out_ready_in(rsp_ready_in),
        .out_data_out(rsp_data_out),
        .level_out(level)
    );

    // Pins. Output enable is released while asleep; the other two selects
    // stay asserted so the first select alone marks an access.
    assign bus.addr = st_q.addr;
    assign bus.adv_ld = st_q.adv_ld;
    assign bus.we_n = st_q.we_n;
    assign bus.byte_lane_write_n = st_q.bw_n;
    assign bus.device_select_1_n = st_q.cs1_n;
    assign bus.device_select_2 = 1'b1;
    assign bus.device_select_3_n = 1'b0;
    assign bus.clock_qualify_n = st_q.cq_n;
    assign bus.oe_n = st_q.sleep;
    assign bus.sleep_request = st_q.sleep;
    assign bus.ctl_dq = st_q.dq;
    assign bus.ctl_dq_oe = st_q.dq_oe & fifo_ready | st_q.dq_oe;
endmodule : sbp_ctl

// ===== src/sbp_defs.svh
// Shared constants for the pipelined synchronous burst memory port.
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH
// Data word, split into four byte lanes of nine bits.
`define SBP_DW 36
`define SBP_LANES 4
`define SBP_LANE_W 9
// Full documented address width and the low bits that index the modelled storage.
`define SBP_AW 18
`define SBP_STORE_AW 4
`define SBP_STORE_DEPTH 16
// Burst counter width: bursts wrap inside four words.
`define SBP_BURST_W 2
// Enabled edges from command sample to data on the bus.
`define SBP_DATA_LAT 2
// Read-data buffer in the controller.
`define SBP_FIFO_DEPTH 16
`define SBP_FIFO_AW 4
`endif

// ===== src/sbp_dev.sv
// Memory device end: pipelined burst memory with byte-lane writes.
// Function
// - Register every synchronous input on rising edge.
// - Read data leaves through an output register.
// - Disabled clock qualify freezes all state.
// - Drivers off during write data phase.
// - New read or write every enabled cycle.
// - Three selects decode; output enable gates asynchronously.
// - Writes update only selected byte lanes.
// - Bursts follow linear or interleaved order.
// - Sleep input idles device; clock may stop.
`timescale 1ns/10ps
`include "sbp_defs.svh"
module sbp_dev (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Pins facing the controller.
    sbp_if.dev bus,
    // Board straps and status.
    input wire logic burst_interleave_in,
    output logic asleep_out
);

    // Whole device state in one register.
    typedef struct packed {
        sbp_pkg::sbp_cmd_t s1;
        sbp_pkg::sbp_cmd_t s2;
        sbp_pkg::sbp_cmd_t s3;
        logic [`SBP_AW-1:0] base;
        logic [`SBP_BURST_W-1:0] cnt;
        sbp_pkg::sbp_op_t last;
        logic drv;
        logic asleep;
        logic [`SBP_DW-1:0] rdata;
        logic [`SBP_STORE_DEPTH-1:0][`SBP_DW-1:0] mem;
    } sbp_dev_st_t;

    sbp_dev_st_t st_q;
    sbp_dev_st_t st_d;
    logic enabled;
    logic selected;

    // Next address inside a four-word burst wrap.
    function automatic logic [`SBP_AW-1:0] burst_addr(
        input logic [`SBP_AW-1:0] base,
        input logic [`SBP_BURST_W-1:0] cnt,
        input logic ilv
    );
        logic [`SBP_BURST_W-1:0] low;
        low = ilv ? (base[`SBP_BURST_W-1:0] ^ cnt) : (base[`SBP_BURST_W-1:0] + cnt);
        burst_addr = {base[`SBP_AW-1:`SBP_BURST_W], low};
    endfunction : burst_addr

    // Storage index from a full address; upper bits alias onto the modelled words.
    function automatic logic [`SBP_STORE_AW-1:0] store_idx(input logic [`SBP_AW-1:0] a);
        store_idx = a[`SBP_STORE_AW-1:0];
    endfunction : store_idx

    // Merge new data into an old word lane by lane.
    function automatic logic [`SBP_DW-1:0] lane_merge(
        input logic [`SBP_DW-1:0] old_w,
        input logic [`SBP_DW-1:0] new_w,
        input logic [`SBP_LANES-1:0] lanes
    );
        lane_merge = old_w;
        for (int i = 0; i < `SBP_LANES; i++) begin
            if (lanes[i]) begin
                lane_merge[i*`SBP_LANE_W +: `SBP_LANE_W] = new_w[i*`SBP_LANE_W +: `SBP_LANE_W];
            end
        end
    endfunction : lane_merge

    // Edge qualification and bank decode of the three selects.
    assign enabled = ~bus.clock_qualify_n;
    assign selected = ~bus.device_select_1_n & bus.device_select_2
        & ~bus.device_select_3_n;

    // Next-state logic. A disabled edge leaves st_d equal to st_q, so the
    // previous cycle simply stretches and nothing in flight is disturbed.
    always_comb begin
        st_d = st_q;
        if (enabled) begin
            // Pipeline advance: one new slot per enabled edge, no bubbles.
            st_d.s2 = st_q.s1;
            st_d.s3 = st_q.s2;
            st_d.asleep = bus.sleep_request;
            // Input register: capture the pins of this edge.
            st_d.s1.op = sbp_pkg::SBP_NOP;
            st_d.s1.addr = bus.addr;
            st_d.s1.lanes = '0;
            if (bus.sleep_request) begin
                // Asleep: new commands are ignored and bursts are broken off.
                st_d.last = sbp_pkg::SBP_NOP;
            end else if (!bus.adv_ld) begin
                // Load cycle: a selected bank starts a new access.
                if (selected) begin
                    st_d.s1.op = bus.we_n ? sbp_pkg::SBP_RD : sbp_pkg::SBP_WR;
                end
                st_d.base = bus.addr;
                st_d.cnt = '0;
                st_d.last = st_d.s1.op;
            end else if (st_q.last != sbp_pkg::SBP_NOP) begin
                // Advance cycle: continue the running burst with the next address.
                st_d.cnt = st_q.cnt + 2'h1;
                st_d.s1.op = st_q.last;
                st_d.s1.addr = burst_addr(st_q.base, st_d.cnt, burst_interleave_in);
            end
            if (st_d.s1.op == sbp_pkg::SBP_WR) begin
                st_d.s1.lanes = ~bus.byte_lane_write_n;
            end
            // Write commit: data of the write sampled three edges ago is on the
            // bus now; only the enabled lanes change.
            if (st_q.s3.op == sbp_pkg::SBP_WR) begin
                st_d.mem[store_idx(st_q.s3.addr)] = lane_merge(
                    st_q.mem[store_idx(st_q.s3.addr)], bus.dq, st_q.s3.lanes);
            end
            // Read launch: reading st_d.mem forwards a write committed on this
            // same edge, so a read right behind a write sees fresh data.
            st_d.drv = 1'b0;
            if (st_q.s2.op == sbp_pkg::SBP_RD) begin
                st_d.rdata = st_d.mem[store_idx(st_q.s2.addr)];
                st_d.drv = 1'b1;
            end
        end
    end

    // State register. Storage is cleared at reset so reads are never unknown.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Output drivers. The enable is gated by the output-enable pin without
    // a clock, so the controller can release the bus at any moment.
    assign bus.dev_dq = st_q.rdata;
    assign bus.dev_dq_oe = st_q.drv & ~bus.oe_n;
    assign asleep_out = st_q.asleep;

    // Timing summary of the pipeline, in enabled edges after the command edge E0:
    // E1 moves the slot to the second stage; E2 loads read data and turns the
    // drivers on for reads or off for writes; E3 captures write data from the
    // bus. A stopped clock or a held qualify pin simply delays every step.

endmodule : sbp_dev

// ===== src/sbp_if.sv
// Pin-level carrier between the memory device and its controller.
`timescale 1ns/10ps
`include "sbp_defs.svh"
interface sbp_if;
    // Command and control pins, driven by the controller.
    logic [`SBP_AW-1:0] addr;
    logic adv_ld;
    logic we_n;
    logic [`SBP_LANES-1:0] byte_lane_write_n;
    logic device_select_1_n;
    logic device_select_2;
    logic device_select_3_n;
    logic clock_qualify_n;
    logic oe_n;
    logic sleep_request;
    // Data bus halves and the resolved wire level.
    logic [`SBP_DW-1:0] dev_dq;
    logic dev_dq_oe;
    logic [`SBP_DW-1:0] ctl_dq;
    logic ctl_dq_oe;
    logic [`SBP_DW-1:0] dq;

    // Whoever enables its driver owns the wire, the device if both do; an idle bus reads as zero.
    assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);

    modport dev (
        input addr, adv_ld, we_n, byte_lane_write_n, device_select_1_n,
        input device_select_2, device_select_3_n, clock_qualify_n, oe_n,
        input sleep_request, dq,
        output dev_dq, dev_dq_oe
    );
    modport ctl (
        output addr, adv_ld, we_n, byte_lane_write_n, device_select_1_n,
        output device_select_2, device_select_3_n, clock_qualify_n, oe_n,
        output sleep_request, ctl_dq, ctl_dq_oe,
        input dq
    );
endinterface : sbp_if

// ===== src/sbp_pkg.sv
// Types shared by both ends of the burst memory port.
`include "sbp_defs.svh"
package sbp_pkg;
    // Kind of operation carried by one pipeline slot.
    typedef enum logic [1:0] {SBP_NOP, SBP_RD, SBP_WR} sbp_op_t;

    // One command as it travels through the device pipeline.
    typedef struct packed {
        sbp_op_t op;
        logic [`SBP_AW-1:0] addr;
        logic [`SBP_LANES-1:0] lanes;
    } sbp_cmd_t;

    // One command as it travels through the controller pipeline.
    typedef struct packed {
        sbp_op_t op;
        logic [`SBP_DW-1:0] wdata;
    } sbp_slot_t;
endpackage : sbp_pkg
